// ===== src/sfb_top.sv
// status and fault register bank: read-only words for a field-bus master
// assumes the register server presents a register number with a read
// or write strobe, and that measurement data for the same number is
// driven back combinationally on meas_rdata_i in that cycle
`timescale 1ns/100ps
`include "sfb_regs.svh"
module sfb_top (
   input wire logic ref_clk_i, // system clock, 20 MHz
   input wire logic nrst_i, // async reset, low
   input wire logic [15:0] reg_num_i, // register number
   input wire logic rd_en_i, // read strobe
   input wire logic wr_en_i, // write strobe
   input wire logic [15:0] meas_rdata_i, // measurement word
   input wire logic [3:0] op_state_i, // state from control
   input wire logic [15:0] main_fault_i, // main fault word
   input wire logic [15:0] drive_fault_i, // drive fault word
   input wire logic [15:0] volt_fault_i, // voltage fault word
   input wire logic [15:0] grid_fault_i, // grid fault word
   input wire logic [15:0] temp_fault_i, // temperature fault
   input wire logic [15:0] sys_fault_i, // system fault word
   input wire logic [15:0] sys_warn_i, // system warnings
   input wire logic rebooting_i, // comm rebooting
   input wire logic comm_fault_i, // internal comm fault
   input wire logic web_post_fault_i, // web post failed
   input wire logic dns_fault_i, // name server fault
   input wire logic rtc_battery_fail_i, // clock battery dead
   input wire logic time_sync_fail_i, // time sync failed
   input wire logic fw_mismatch_i, // wrong comm firmware
   input wire logic addr_switch_fail_i, // address switches bad
   output logic rd_valid_o, // read answer pulse
   output logic [15:0] rd_data_o, // read answer word
   output logic rd_illegal_o, // unmapped register
   output logic wr_refused_o // write ignored pulse
);
   sfb_if bus ();
   sfb_pkg::sfb_bank_type cur;
   sfb_pkg::sfb_bank_type nxt;
   logic in_meas;
   logic [15:0] data;
   logic illegal;

   ////////////////////////////////////////////////////////////////////
   // encoder holds the filtered state and the monitoring word
   sfb_status_encoder u_enc (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .op_state_i(op_state_i),
      .rebooting_i(rebooting_i),
      .comm_fault_i(comm_fault_i),
      .web_post_fault_i(web_post_fault_i),
      .dns_fault_i(dns_fault_i),
      .rtc_battery_fail_i(rtc_battery_fail_i),
      .time_sync_fail_i(time_sync_fail_i),
      .fw_mismatch_i(fw_mismatch_i),
      .addr_switch_fail_i(addr_switch_fail_i),
      .bus(bus)
   );

   ////////////////////////////////////////////////////////////////////
   // read decode; measurement data only passes while comm is healthy
   always_comb begin
      in_meas = (reg_num_i >= `SFB_MEAS_FIRST) &&
         (reg_num_i <= `SFB_MEAS_LAST);
      illegal = 1'b0;
      data = `SFB_RST_WORD;
      if (in_meas) begin
         // the encoder copy lags the pin by one cycle, so a fault
         // that just began may still let one stale word through
         data = bus.comm_fault ? `SFB_RST_WORD : meas_rdata_i;
      end else begin
         case (reg_num_i)
            `SFB_REG_OP_STATE: data = bus.op_state_word;
            `SFB_REG_MAIN_FAULT: data = main_fault_i;
            `SFB_REG_DRIVE_FAULT: data = drive_fault_i;
            `SFB_REG_VOLT_FAULT: data = volt_fault_i;
            `SFB_REG_GRID_FAULT: data = grid_fault_i;
            `SFB_REG_TEMP_FAULT: data = temp_fault_i;
            `SFB_REG_SYS_FAULT: data = sys_fault_i;
            `SFB_REG_SYS_WARN: data = sys_warn_i;
            `SFB_REG_MON_STATUS: data = bus.mon_status;
            default: illegal = 1'b1;
         endcase
      end
   end

   // answer register; the data word holds between reads
   always_comb begin
      nxt = cur;
      nxt.rd_valid = rd_en_i;
      nxt.rd_illegal = rd_en_i & illegal;
      // no storage behind a write, so it is only flagged
      nxt.wr_refused = wr_en_i;
      if (rd_en_i) begin
         nxt.rd_data = data;
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cur.rd_valid <= 1'b0;
         cur.rd_data <= `SFB_RST_WORD;
         cur.rd_illegal <= 1'b0;
         cur.wr_refused <= 1'b0;
      end else begin
         cur <= nxt;
      end
   end

   // outputs straight from the flops
   assign rd_valid_o = cur.rd_valid;
   assign rd_data_o = cur.rd_data;
   assign rd_illegal_o = cur.rd_illegal;
   assign wr_refused_o = cur.wr_refused;

   ////////////////////////////////////////////////////////////////////
   // read requests as named sequences
   sequence s_rd_state;
      rd_en_i && (reg_num_i == `SFB_REG_OP_STATE);
   endsequence
   sequence s_rd_main;
      rd_en_i && (reg_num_i == `SFB_REG_MAIN_FAULT);
   endsequence
   sequence s_rd_warn;
      rd_en_i && (reg_num_i == `SFB_REG_SYS_WARN);
   endsequence
   sequence s_rd_mon;
      rd_en_i && (reg_num_i == `SFB_REG_MON_STATUS);
   endsequence
   sequence s_rd_meas;
      rd_en_i && (reg_num_i >= `SFB_MEAS_FIRST) &&
         (reg_num_i <= `SFB_MEAS_LAST);
   endsequence

   chk_state_read: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      s_rd_state |=> rd_valid_o && !rd_illegal_o &&
         (rd_data_o == $past(bus.op_state_word)))
      else $error("state read returned wrong word");
   chk_state_range: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      s_rd_state |=> (rd_data_o[15:4] == 12'h000))
      else $error("state word has high bits set");
   chk_state_follow: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      ((op_state_i == `SFB_ST_FAULT) ##1 s_rd_state) |=>
         (rd_data_o == 16'h0009))
      else $error("fault state not reported as 9");
   chk_main_read: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      s_rd_main |=> rd_valid_o && (rd_data_o == $past(main_fault_i)))
      else $error("main fault read wrong");
   chk_warn_read: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      s_rd_warn |=> rd_valid_o && (rd_data_o == $past(sys_warn_i)))
      else $error("warning read wrong");
   chk_mon_code: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (web_post_fault_i && dns_fault_i) ##1 s_rd_mon |=>
         (rd_data_o[3:2] == 2'b11))
      else $error("monitoring codes 4 and 8 missing");
   chk_mon_read: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      s_rd_mon |=> (rd_data_o == $past(bus.mon_status)))
      else $error("monitoring read wrong");
   chk_meas_zero: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (comm_fault_i ##1 (s_rd_meas and comm_fault_i)) |=>
         rd_valid_o && (rd_data_o == 16'h0000))
      else $error("measurement not zero during comm fault");
   chk_meas_pass: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (s_rd_meas and !bus.comm_fault) |=>
         !rd_illegal_o && (rd_data_o == $past(meas_rdata_i)))
      else $error("measurement word not passed");
   chk_write_ignored: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (wr_en_i && !rd_en_i) |=> wr_refused_o && !rd_valid_o &&
         $stable(rd_data_o))
      else $error("write disturbed the bank");

   ////////////////////////////////////////////////////////////////////
   // remaining fault words, one read request each
   sequence s_rd_drive;
      rd_en_i && (reg_num_i == `SFB_REG_DRIVE_FAULT);
   endsequence
   sequence s_rd_volt;
      rd_en_i && (reg_num_i == `SFB_REG_VOLT_FAULT);
   endsequence
   sequence s_rd_grid;
      rd_en_i && (reg_num_i == `SFB_REG_GRID_FAULT);
   endsequence
   sequence s_rd_temp;
      rd_en_i && (reg_num_i == `SFB_REG_TEMP_FAULT);
   endsequence
   sequence s_rd_sys;
      rd_en_i && (reg_num_i == `SFB_REG_SYS_FAULT);
   endsequence

   // every fault word is sampled at the read edge, no encoder lag
   chk_drive_read: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      s_rd_drive |=> rd_valid_o && (rd_data_o == $past(drive_fault_i)))
      else $error("drive fault read wrong");
   chk_volt_read: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      s_rd_volt |=> rd_valid_o && (rd_data_o == $past(volt_fault_i)))
      else $error("voltage fault read wrong");
   chk_grid_read: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      s_rd_grid |=> rd_valid_o && (rd_data_o == $past(grid_fault_i)))
      else $error("grid fault read wrong");
   chk_temp_read: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      s_rd_temp |=> rd_valid_o && (rd_data_o == $past(temp_fault_i)))
      else $error("temperature fault read wrong");
   chk_sys_read: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      s_rd_sys |=> rd_valid_o && (rd_data_o == $past(sys_fault_i)))
      else $error("system fault read wrong");
   chk_unmapped_read: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (rd_en_i && !in_meas && ((reg_num_i < `SFB_REG_OP_STATE) ||
         (reg_num_i > `SFB_REG_MON_STATUS))) |=>
         rd_illegal_o && (rd_data_o == 16'h0000))
      else $error("unmapped read not flagged");

   // answer pulses last one cycle and the word holds between reads
   chk_valid_pulse: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      !rd_en_i |=> !rd_valid_o && !rd_illegal_o)
      else $error("read answer without a read");
   chk_refused_pulse: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      !wr_en_i |=> !wr_refused_o)
      else $error("write flag without a write");
   chk_data_holds: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      !rd_en_i |=> $stable(rd_data_o))
      else $error("read word changed without a read");

   // encoder word as seen by the read port
   chk_state_low_pass: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (op_state_i <= `SFB_ST_TRACK) |=>
         (bus.op_state_word == {12'h000, $past(op_state_i)}))
      else $error("low state code not passed");
   chk_state_high_pass: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      ((op_state_i >= `SFB_ST_FAULT) && (op_state_i <= `SFB_ST_COOL)) |=>
         (bus.op_state_word == {12'h000, $past(op_state_i)}))
      else $error("high state code not passed");
   chk_state_hold: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (((op_state_i > `SFB_ST_TRACK) && (op_state_i < `SFB_ST_FAULT)) ||
         (op_state_i > `SFB_ST_COOL)) |=> $stable(bus.op_state_word))
      else $error("reserved state code not held");
   chk_comm_follow: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      comm_fault_i |=> bus.comm_fault)
      else $error("comm fault not carried");
   chk_comm_clear: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      !comm_fault_i |=> !bus.comm_fault)
      else $error("comm fault stuck");

   // monitoring codes one by one, then all together
   chk_mon_reboot: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      rebooting_i |=> bus.mon_status[0])
      else $error("reboot code missing");
   chk_mon_web: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      web_post_fault_i |=> bus.mon_status[2])
      else $error("web post code missing");
   chk_mon_dns: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      dns_fault_i |=> bus.mon_status[3])
      else $error("name server code missing");
   chk_mon_battery: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      rtc_battery_fail_i |=> bus.mon_status[4])
      else $error("battery clock error missing");
   chk_mon_sync: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      time_sync_fail_i |=> bus.mon_status[4])
      else $error("sync clock error missing");
   chk_mon_fw: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      fw_mismatch_i |=> bus.mon_status[5])
      else $error("firmware code missing");
   chk_mon_addr: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      addr_switch_fail_i |=> bus.mon_status[6])
      else $error("address switch code missing");
   chk_mon_all: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (rebooting_i && comm_fault_i && web_post_fault_i && dns_fault_i &&
         time_sync_fail_i && fw_mismatch_i && addr_switch_fail_i) |=>
         (bus.mon_status == 16'h007F))
      else $error("monitoring sum wrong with all codes");
endmodule

// ===== src/sfb_regs.svh
// register numbers, status codes and field values of the status bank
// assumes inclusion by bare name from every file that decodes them
`ifndef SFB_REGS_SVH
`define SFB_REGS_SVH
// register numbers, 0-based start registers
`define SFB_REG_OP_STATE 16'h0834
`define SFB_REG_MAIN_FAULT 16'h0835
`define SFB_REG_DRIVE_FAULT 16'h0836
`define SFB_REG_VOLT_FAULT 16'h0837
`define SFB_REG_GRID_FAULT 16'h0838
`define SFB_REG_TEMP_FAULT 16'h0839
`define SFB_REG_SYS_FAULT 16'h083A
`define SFB_REG_SYS_WARN 16'h083B
`define SFB_REG_MON_STATUS 16'h083C
// measurement block forced to zero on communication fault
`define SFB_MEAS_FIRST 16'h03E8
`define SFB_MEAS_LAST 16'h0403
// operating state codes
`define SFB_ST_SLEEP 4'h0
`define SFB_ST_TRACK 4'h5
`define SFB_ST_FAULT 4'h9
`define SFB_ST_INIT 4'hA
`define SFB_ST_COOL 4'hD
// monitoring status code values
`define SFB_MON_REBOOT 16'h0001
`define SFB_MON_COMM 16'h0002
`define SFB_MON_WEB 16'h0004
`define SFB_MON_DNS 16'h0008
`define SFB_MON_CLOCK 16'h0010
`define SFB_MON_FW 16'h0020
`define SFB_MON_ADDR 16'h0040
// reset values
`define SFB_RST_WORD 16'h0000
`endif

// ===== src/sfb_pkg.sv
// types shared by the status bank modules
// assumes the constants come from sfb_regs.svh
package sfb_pkg;
   typedef logic [15:0] sfb_word_type;
   // encoder state: last legal state code and monitoring word
   typedef struct packed {
      logic [3:0] op_state;
      sfb_word_type mon;
   } sfb_enc_type;
   // read port state of the bank
   typedef struct packed {
      logic rd_valid;
      sfb_word_type rd_data;
      logic rd_illegal;
      logic wr_refused;
   } sfb_bank_type;
endpackage

// ===== src/sfb_if.sv
// carrier from the status encoder to the read port of the bank
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface sfb_if;
   logic [15:0] op_state_word;
   logic [15:0] mon_status;
   logic comm_fault;
   modport enc (output op_state_word, output mon_status, output comm_fault);
   modport bank (input op_state_word, input mon_status, input comm_fault);
endinterface

// ===== src/sfb_status_encoder.sv
// status encoder: filters the operating state and sums monitoring codes
// assumes all inputs come from control logic on ref_clk_i
`timescale 1ns/100ps
`include "sfb_regs.svh"
module sfb_status_encoder (
   input wire logic ref_clk_i, // system clock
   input wire logic nrst_i, // async reset, low
   input wire logic [3:0] op_state_i, // state from control
   input wire logic rebooting_i, // comm section rebooting
   input wire logic comm_fault_i, // internal comm fault
   input wire logic web_post_fault_i, // web post failed
   input wire logic dns_fault_i, // name server fault
   input wire logic rtc_battery_fail_i, // clock battery dead
   input wire logic time_sync_fail_i, // time sync failed
   input wire logic fw_mismatch_i, // wrong comm firmware
   input wire logic addr_switch_fail_i, // address switch read failed
   sfb_if.enc bus // encoded words out
);
   sfb_pkg::sfb_enc_type cur;
   sfb_pkg::sfb_enc_type nxt;
   logic legal;
   logic clock_err;

   ////////////////////////////////////////////////////////////////////
   // legal codes pass, reserved and unknown codes hold the last one
   always_comb begin
      legal = (op_state_i <= `SFB_ST_TRACK) ||
         ((op_state_i >= `SFB_ST_FAULT) && (op_state_i <= `SFB_ST_COOL));
      clock_err = rtc_battery_fail_i | time_sync_fail_i;
      nxt = cur;
      if (legal) begin
         nxt.op_state = op_state_i;
      end
      // a sum, not an or; the two clock faults share one code and are ored first
      nxt.mon = `SFB_RST_WORD;
      if (rebooting_i) nxt.mon = nxt.mon + `SFB_MON_REBOOT;
      if (comm_fault_i) nxt.mon = nxt.mon + `SFB_MON_COMM;
      if (web_post_fault_i) nxt.mon = nxt.mon + `SFB_MON_WEB;
      if (dns_fault_i) nxt.mon = nxt.mon + `SFB_MON_DNS;
      if (clock_err) nxt.mon = nxt.mon + `SFB_MON_CLOCK;
      if (fw_mismatch_i) nxt.mon = nxt.mon + `SFB_MON_FW;
      if (addr_switch_fail_i) nxt.mon = nxt.mon + `SFB_MON_ADDR;
   end

   // state register, comes up in initialization
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cur.op_state <= `SFB_ST_INIT;
         cur.mon <= `SFB_RST_WORD;
      end else begin
         cur <= nxt;
      end
   end

   // words to the bank
   assign bus.op_state_word = {12'h000, cur.op_state};
   assign bus.mon_status = cur.mon;
   assign bus.comm_fault = cur.mon[1];

   ////////////////////////////////////////////////////////////////////
   chk_state_never_reserved: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (cur.op_state <= `SFB_ST_TRACK) ||
      ((cur.op_state >= `SFB_ST_FAULT) && (cur.op_state <= `SFB_ST_COOL)))
      else $error("reserved operating state reported");
   chk_clock_err_raise: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (rtc_battery_fail_i || time_sync_fail_i) |=> (cur.mon[4] == 1'b1))
      else $error("clock error code not raised");
   chk_idle_reads_zero: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      !(rebooting_i | comm_fault_i | web_post_fault_i | dns_fault_i |
      rtc_battery_fail_i | time_sync_fail_i | fw_mismatch_i |
      addr_switch_fail_i) |=> (cur.mon == 16'h0000))
      else $error("monitoring word not zero when idle");
endmodule

// ===== tb/sfb_meas_model.sv
// measurement source model: answers a register number with a data word
// assumes the bank reads it combinationally in the cycle of the read
`timescale 1ns/100ps
module sfb_meas_model (
   input wire logic [15:0] reg_num_i, // register number asked for
   output logic [15:0] meas_rdata_o // measurement word back
);
   ////////////////////////////////////////////////////////////////////////
   // the measurement block gives a pattern per register; elsewhere the
   // inverse, so that a stale or misrouted word never reads as zero
   always_comb begin
      if (reg_num_i >= 16'h03E8 && reg_num_i <= 16'h0403) begin
         meas_rdata_o = reg_num_i ^ 16'h5A5A;
      end else begin
         meas_rdata_o = ~reg_num_i;
      end
   end
endmodule

// ===== tb/sfb_top_tb.sv
// self-checking bench for the status and fault register bank
// assumes the design sources and sfb_regs.svh are compiled first
`timescale 1ns/100ps
`include "sfb_regs.svh"
module sfb_top_tb;
   logic ref_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [15:0] reg_num = 16'h0000;
   logic rd_en = 1'b0;
   logic wr_en = 1'b0;
   logic [3:0] op_state = 4'h0;
   logic [7:0] flags = 8'h00;
   logic [15:0] fault_w [0:6] = '{16'h1001, 16'h2002, 16'h3003, 16'h4004,
      16'h5005, 16'h6006, 16'h7007};
   logic [15:0] meas_rdata;
   logic [15:0] rd_data;
   logic rd_valid;
   logic rd_illegal;
   logic wr_refused;
   int errors = 0;
   int checked = 0;

   ////////////////////////////////////////////////////////////////////////
   // 20 MHz clock
   always #25 ref_clk_i = ~ref_clk_i;

   sfb_meas_model meas (.reg_num_i(reg_num), .meas_rdata_o(meas_rdata));

   sfb_top DUT (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .reg_num_i(reg_num),
      .rd_en_i(rd_en), .wr_en_i(wr_en), .meas_rdata_i(meas_rdata),
      .op_state_i(op_state), .main_fault_i(fault_w[0]), .drive_fault_i(fault_w[1]),
      .volt_fault_i(fault_w[2]), .grid_fault_i(fault_w[3]), .temp_fault_i(fault_w[4]),
      .sys_fault_i(fault_w[5]), .sys_warn_i(fault_w[6]), .rebooting_i(flags[0]),
      .comm_fault_i(flags[1]), .web_post_fault_i(flags[2]), .dns_fault_i(flags[3]),
      .rtc_battery_fail_i(flags[4]), .time_sync_fail_i(flags[5]),
      .fw_mismatch_i(flags[6]), .addr_switch_fail_i(flags[7]), .rd_valid_o(rd_valid),
      .rd_data_o(rd_data), .rd_illegal_o(rd_illegal), .wr_refused_o(wr_refused));

   ////////////////////////////////////////////////////////////////////////
   // compare tasks, one per kind of result
   task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_bit(input string what, input logic exp, input logic got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %b seen %b", what, exp, got);
      end
   endtask

   // one read: strobe at a falling edge, answer judged one cycle later
   task automatic rd(input logic [15:0] num, input logic [15:0] exp, input logic bad);
      @(negedge ref_clk_i);
      reg_num = num;
      rd_en = 1'b1;
      @(negedge ref_clk_i);
      rd_en = 1'b0;
      chk_bit("rd_valid", 1'b1, rd_valid);
      chk_bit("rd_illegal", bad, rd_illegal);
      chk_word("rd_data", exp, rd_data);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // every state code; reserved ones must leave the last legal code
   task automatic test_states;
      logic [15:0] last;
      last = 16'h0000;
      for (int v = 0; v < 16; v++) begin
         op_state = 4'(v);
         if (v < 6 || (v > 8 && v < 14)) last = 16'(v);
         rd(`SFB_REG_OP_STATE, last, 1'b0);
      end
   endtask

   // fault words and warnings in register order
   task automatic test_faults;
      for (int i = 0; i < 7; i++) begin
         rd(`SFB_REG_MAIN_FAULT + 16'(i), fault_w[i], 1'b0);
      end
   endtask

   // each monitoring condition alone, then all at once
   task automatic test_monitor;
      int wt [0:7] = '{1, 2, 4, 8, 16, 16, 32, 64};
      flags = 8'h00;
      rd(`SFB_REG_MON_STATUS, 16'h0000, 1'b0);
      for (int i = 0; i < 8; i++) begin
         flags = 8'h01 << i;
         rd(`SFB_REG_MON_STATUS, 16'(wt[i]), 1'b0);
      end
      flags = 8'hFF;
      rd(`SFB_REG_MON_STATUS, 16'h007F, 1'b0);
      flags = 8'h00;
   endtask

   // measurement reads pass, then read zero while comm fault stands
   task automatic test_meas;
      rd(16'h03E8, 16'h03E8 ^ 16'h5A5A, 1'b0);
      rd(16'h0403, 16'h0403 ^ 16'h5A5A, 1'b0);
      flags = 8'h02;
      rd(16'h03E8, 16'h0000, 1'b0);
      rd(16'h0403, 16'h0000, 1'b0);
      rd(`SFB_REG_OP_STATE, 16'h000D, 1'b0);
      rd(16'h083D, 16'h0000, 1'b1);
      flags = 8'h00;
   endtask

   // a write is refused for one cycle and changes nothing
   task automatic test_write;
      @(negedge ref_clk_i);
      reg_num = `SFB_REG_OP_STATE;
      wr_en = 1'b1;
      @(negedge ref_clk_i);
      wr_en = 1'b0;
      chk_bit("wr_refused", 1'b1, wr_refused);
      chk_bit("rd_valid", 1'b0, rd_valid);
      @(negedge ref_clk_i);
      chk_bit("wr_refused", 1'b0, wr_refused);
      rd(`SFB_REG_OP_STATE, 16'h000D, 1'b0);
   endtask

   task automatic wrap_up;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // main sequence; reset held for four cycles
   initial begin
      repeat (4) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      chk_bit("rd_valid", 1'b0, rd_valid);
      chk_word("rd_data", 16'h0000, rd_data);
      nrst_i = 1'b1;
      test_states();
      test_faults();
      test_monitor();
      test_meas();
      test_write();
      wrap_up();
   end

   // watchdog: the run needs about a hundred cycles
   initial begin
      #(50 * 2000);
      errors++;
      wrap_up();
   end
endmodule
